//--- shared/chtrim_consts.svh
// Register offsets, field positions, reset values and trim constants of the channel trim bank.
`ifndef CHTRIM_CONSTS_SVH
`define CHTRIM_CONSTS_SVH

`define CHTRIM_IDX_OFS1        4'h2
`define CHTRIM_IDX_FS1         4'h3
`define CHTRIM_IDX_OFS2        4'hA
`define CHTRIM_IDX_STATUS      4'hF
`define CHTRIM_ADDR_W          6
`define CHTRIM_MAG_MSB         15
`define CHTRIM_MAG_LSB         8
`define CHTRIM_SIGN_BIT        7
`define CHTRIM_FS_MSB          15
`define CHTRIM_FS_LSB          7
`define CHTRIM_OFS_RESET       16'h007F
`define CHTRIM_FS_RESET        16'h807F
`define CHTRIM_FS_NOMINAL      9'h100
`define CHTRIM_FS_MIN_MV       560
`define CHTRIM_FS_NOM_MV       700
`define CHTRIM_OFS_MAX_UV      45000
`define CHTRIM_OFS_STEP_NV     176000
`define CHTRIM_WR_CNT_W        8

`endif

//--- shared/chtrim_pkg.sv
// Types shared by the channel trim bank.
package chtrim_pkg;

   typedef struct packed {
      logic [7:0] magnitude;
      logic       negative;
   } chtrim_offset_s;

   typedef struct packed {
      chtrim_offset_s ofs1;
      logic [8:0]     fs1;
      chtrim_offset_s ofs2;
   } chtrim_trim_s;

   typedef enum logic [1:0] {
      CHTRIM_IDLE   = 2'b00,
      CHTRIM_ACCESS = 2'b01
   } chtrim_state_e;

endpackage

//--- core/chtrim_offset_reg.sv
// One offset trim register: magnitude plus sign, cleared at reset.
`timescale 1ns/1ps
`include "chtrim_consts.svh"

module chtrim_offset_reg (
   input  wire logic                   core_clk, // Core clock.
   input  wire logic                   resetn,   // Asynchronous reset, active low.
   input  wire logic                   wr_en,    // Write strobe for this register.
   input  wire logic [15:0]            wr_data,  // Written word.
   output chtrim_pkg::chtrim_offset_s  trim      // Held offset code.
);

   chtrim_pkg::chtrim_offset_s trim_r;
   chtrim_pkg::chtrim_offset_s trim_nxt;

   always_comb begin
      trim_nxt = trim_r;
      if (wr_en) begin
         trim_nxt.magnitude = wr_data[`CHTRIM_MAG_MSB:`CHTRIM_MAG_LSB]; // RULE_01
         trim_nxt.negative  = wr_data[`CHTRIM_SIGN_BIT];                // RULE_03
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         trim_r <= '0; // RULE_04
      end else begin
         trim_r <= trim_nxt;
      end
   end

   assign trim = trim_r;

   a_offset_load : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
      wr_en |=> trim_r.magnitude == $past(wr_data[15:8]) && trim_r.negative == $past(wr_data[7]))
      else $error("offset register did not load written code");
   a_offset_hold : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_03
      !wr_en |=> $stable(trim_r))
      else $error("offset register changed without a write");

endmodule

//--- core/chtrim_regs.sv
// APB register bank holding the channel offset and full-scale trim codes.
//
// Notes on behaviour
// RULE_01: First-channel offset magnitude is bits 15:8, unsigned, linear and monotonic.
// RULE_02: Magnitude 00h is zero offset, FFh about 45 mV, 0.176 mV per step.
// RULE_03: Bit 7 is offset sign: zero positive, one negative.
// RULE_04: After reset offset magnitude and sign are zero, so no offset.
// RULE_05: First-channel full-scale adjust is nine bits, 15:7, around 700 mV nominal.
// RULE_06: Code zero gives 560 mV, 100h gives 700 mV, 1FFh gives 840 mV.
// RULE_07: Host should keep full-scale code between 0C0h and 1C0h.
// RULE_08: Full-scale change applies at once, without a new calibration.
// RULE_09: After reset full-scale code is 100h, meaning no adjustment.
// RULE_10: Second-channel offset has same layout and reset as the first.
// RULE_11: Host writes ones into bits 6:0 of every trim register.
// RULE_12: Trim registers are write-only; reads of them return zero.
`timescale 1ns/1ps
`include "chtrim_consts.svh"

module chtrim_regs (
   input  wire logic                         core_clk,      // Core clock, 125 MHz.
   input  wire logic                         resetn,        // Asynchronous reset, active low.
   input  wire logic                         psel,          // APB select.
   input  wire logic                         penable,       // APB access phase.
   input  wire logic                         pwrite,        // APB direction, high for write.
   input  wire logic [`CHTRIM_ADDR_W-1:0]    paddr,         // APB byte address.
   input  wire logic [31:0]                  pwdata,        // APB write data.
   output logic      [31:0]                  prdata,        // APB read data.
   output logic                              pready,        // APB ready.
   output logic                              pslverr,       // APB error for unmapped address.
   output logic      [7:0]                   ofs1_mag,      // First-channel offset magnitude.
   output logic                              ofs1_neg,      // First-channel offset negative.
   output logic      [8:0]                   fs1_code,      // First-channel full-scale code.
   output logic                              fs1_update,    // Pulse: new full-scale code live.
   output logic      [7:0]                   ofs2_mag,      // Second-channel offset magnitude.
   output logic                              ofs2_neg       // Second-channel offset negative.
);

   chtrim_pkg::chtrim_state_e      state_r;
   chtrim_pkg::chtrim_state_e      state_nxt;
   logic [31:0]                    prdata_r;
   logic [31:0]                    prdata_nxt;
   logic                           pslverr_r;
   logic                           pslverr_nxt;
   logic                           pready_r;
   logic                           pready_nxt;
   logic [8:0]                     fs1_r;
   logic [8:0]                     fs1_nxt;
   logic                           fs1_upd_r;
   logic                           fs1_upd_nxt;
   logic [`CHTRIM_WR_CNT_W-1:0]    wr_cnt_r;
   logic [`CHTRIM_WR_CNT_W-1:0]    wr_cnt_nxt;
   logic                           ofs_guard_r;
   logic                           ofs_guard_nxt;
   logic [3:0]                     idx;
   logic                           take;
   logic                           wr_take;
   logic                           hit_ofs1;
   logic                           hit_fs1;
   logic                           hit_ofs2;
   logic                           hit_stat;
   logic                           mapped;
   chtrim_pkg::chtrim_offset_s     ofs1;
   chtrim_pkg::chtrim_offset_s     ofs2;

   // Offsets are printed as indices, so the word index is the address over four.
   assign idx      = paddr[5:2];
   assign take     = psel && penable && (state_r == chtrim_pkg::CHTRIM_ACCESS);
   assign wr_take  = take && pwrite;
   assign hit_ofs1 = (idx == `CHTRIM_IDX_OFS1);
   assign hit_fs1  = (idx == `CHTRIM_IDX_FS1);
   assign hit_ofs2 = (idx == `CHTRIM_IDX_OFS2);
   assign hit_stat = (idx == `CHTRIM_IDX_STATUS);
   assign mapped   = (paddr[1:0] == 2'h0) && (hit_ofs1 || hit_fs1 || hit_ofs2 || hit_stat);

   chtrim_offset_reg u_ofs1 (
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr_en    (wr_take && mapped && hit_ofs1),
      .wr_data  (pwdata[15:0]),
      .trim     (ofs1)
   );

   chtrim_offset_reg u_ofs2 (                                       // RULE_10
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr_en    (wr_take && mapped && hit_ofs2),
      .wr_data  (pwdata[15:0]),
      .trim     (ofs2)
   );

   // Bus sequencing: every transfer is answered in its first access cycle.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         chtrim_pkg::CHTRIM_IDLE: begin
            if (psel && !penable) begin
               state_nxt = chtrim_pkg::CHTRIM_ACCESS;
            end
         end
         chtrim_pkg::CHTRIM_ACCESS: begin
            if (psel && !penable) begin
               state_nxt = chtrim_pkg::CHTRIM_ACCESS;
            end else if (!penable || take) begin
               state_nxt = chtrim_pkg::CHTRIM_IDLE;
            end
         end
         default: begin
            state_nxt = chtrim_pkg::CHTRIM_IDLE;
         end
      endcase
      // Ready is a flop of its own so the bus sees it straight from a register.
      pready_nxt = (state_nxt == chtrim_pkg::CHTRIM_ACCESS);
   end

   // Read data and error are computed in setup so they stand in the access cycle.
   always_comb begin
      prdata_nxt  = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (psel && !penable) begin
         if (!((paddr[1:0] == 2'h0) && (hit_ofs1 || hit_fs1 || hit_ofs2 || hit_stat))) begin
            pslverr_nxt = 1'b1;
         end else if (hit_stat && !pwrite) begin
            prdata_nxt = {23'h000000, ofs_guard_r, wr_cnt_r};
         end
         // Trim registers have no readback path and return zero.        // RULE_12
      end
   end

   // A full-scale write goes straight to the trim DAC, with no calibration pass.
   always_comb begin
      fs1_nxt     = fs1_r;
      fs1_upd_nxt = 1'b0;
      if (wr_take && mapped && hit_fs1) begin
         fs1_nxt     = pwdata[`CHTRIM_FS_MSB:`CHTRIM_FS_LSB];              // RULE_05
         fs1_upd_nxt = 1'b1;                                               // RULE_08
      end
   end

   // Status holds a write count and a sticky flag for a must-be-one low bit left clear.
   // A status write is never a trim write, so the set is given priority only for safety.
   always_comb begin
      wr_cnt_nxt    = wr_cnt_r;
      ofs_guard_nxt = ofs_guard_r;
      if (wr_take && mapped && !hit_stat) begin
         wr_cnt_nxt = wr_cnt_r + 8'h01;
         if (pwdata[6:0] != 7'h7F) begin
            ofs_guard_nxt = 1'b1;                                          // RULE_11
         end
      end else if (wr_take && mapped && hit_stat && pwdata[8]) begin
         ofs_guard_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= chtrim_pkg::CHTRIM_IDLE;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         pready_r  <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         pready_r  <= pready_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fs1_r     <= `CHTRIM_FS_NOMINAL;                                  // RULE_09
         fs1_upd_r <= 1'b0;
      end else begin
         fs1_r     <= fs1_nxt;
         fs1_upd_r <= fs1_upd_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_cnt_r    <= 8'h00;
         ofs_guard_r <= 1'b0;
      end else begin
         wr_cnt_r    <= wr_cnt_nxt;
         ofs_guard_r <= ofs_guard_nxt;
      end
   end

   // Codes drive the analog trim DACs directly: linear, code 100h is nominal.
   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign ofs1_mag   = ofs1.magnitude;                                     // RULE_02
   assign ofs1_neg   = ofs1.negative;
   assign fs1_code   = fs1_r;                                              // RULE_06
   assign fs1_update = fs1_upd_r;
   assign ofs2_mag   = ofs2.magnitude;
   assign ofs2_neg   = ofs2.negative;

   // Trim code loading.
   a_fs_load : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_05
      wr_take && mapped && hit_fs1 |=> fs1_code == $past(pwdata[15:7]) && fs1_update)
      else $error("full-scale code not applied after write");
   a_fs_hold : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_08
      !(wr_take && mapped && hit_fs1) |=> $stable(fs1_code) && !fs1_update)
      else $error("full-scale code changed without write");
   a_fs_pulse : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_08
      fs1_update |=> !fs1_update)
      else $error("full-scale update pulse longer than one cycle");
   a_upd_only : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_08
      fs1_update |-> $past(wr_take) && $past(mapped) && $past(hit_fs1))
      else $error("full-scale update pulse without a write");
   a_fs_cross : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_05
      wr_take && mapped && hit_fs1 |=> $stable(ofs1_mag) && $stable(ofs2_mag))
      else $error("full-scale write disturbed an offset");
   a_ofs1_map : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
      wr_take && mapped && hit_ofs1 |=> ofs1_mag == $past(pwdata[15:8]))
      else $error("first offset magnitude not loaded");
   a_ofs1_sign : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_03
      wr_take && mapped && hit_ofs1 |=> ofs1_neg == $past(pwdata[7]))
      else $error("first offset sign not loaded");
   a_ofs1_hold : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
      !(wr_take && mapped && hit_ofs1) |=> $stable(ofs1_mag) && $stable(ofs1_neg))
      else $error("first offset changed without write");
   a_ofs1_cross : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_10
      wr_take && mapped && hit_ofs1 |=> $stable(fs1_code) && $stable(ofs2_mag)
         && $stable(ofs2_neg))
      else $error("first offset write disturbed another code");
   a_ofs2_map : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_10
      wr_take && mapped && hit_ofs2 |=> ofs2_mag == $past(pwdata[15:8]) && $stable(ofs1_mag))
      else $error("second offset not loaded independently");
   a_ofs2_sign : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_10
      wr_take && mapped && hit_ofs2 |=> ofs2_neg == $past(pwdata[7]))
      else $error("second offset sign not loaded");
   a_ofs2_hold : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_10
      !(wr_take && mapped && hit_ofs2) |=> $stable(ofs2_mag) && $stable(ofs2_neg))
      else $error("second offset changed without write");

   // Bus answers.
   a_wo_read : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_12
      take && !pwrite && !hit_stat |-> prdata == 32'h0000_0000)
      else $error("trim register returned data on read");
   a_read_quiet : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_12
      take && !pwrite |=> $stable(fs1_code) && $stable(ofs1_mag) && $stable(ofs2_mag)
         && $stable(wr_cnt_r))
      else $error("read changed a register");
   a_ready_time : assert property (@(posedge core_clk) disable iff (!resetn)
      psel && !penable ##1 psel && penable |-> pready)
      else $error("access phase not answered at once");
   a_ready_drop : assert property (@(posedge core_clk) disable iff (!resetn)
      take |=> !pready)
      else $error("ready stayed high after a transfer");
   a_idle_quiet : assert property (@(posedge core_clk) disable iff (!resetn)
      !pready |-> !pslverr && prdata == 32'h0000_0000)
      else $error("bus answer outside an access cycle");
   a_err_resp : assert property (@(posedge core_clk) disable iff (!resetn)
      take |-> pslverr == !mapped)
      else $error("error response does not match the address map");
   a_err_nowrite : assert property (@(posedge core_clk) disable iff (!resetn)
      take && !mapped |=> $stable(fs1_code) && $stable(ofs1_mag) && $stable(ofs2_mag)
         && $stable(wr_cnt_r))
      else $error("refused transfer changed a register");
   a_stat_nowrite : assert property (@(posedge core_clk) disable iff (!resetn)
      wr_take && mapped && hit_stat |=> $stable(fs1_code) && $stable(ofs1_mag)
         && $stable(ofs2_mag))
      else $error("status write changed a trim code");
   a_stat_read : assert property (@(posedge core_clk) disable iff (!resetn)
      take && !pwrite && mapped && hit_stat |-> prdata == {23'h000000, ofs_guard_r, wr_cnt_r})
      else $error("status read data wrong");

   // Status bookkeeping.
   a_guard_flag : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_11
      wr_take && mapped && !hit_stat && pwdata[6:0] != 7'h7F |=> ofs_guard_r)
      else $error("low-bit guard flag not set");
   a_guard_clear : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_11
      wr_take && mapped && hit_stat && pwdata[8] |=> !ofs_guard_r)
      else $error("low-bit guard flag not cleared");
   a_guard_sticky : assert property (@(posedge core_clk) disable iff (!resetn) // RULE_11
      ofs_guard_r && !(wr_take && mapped && hit_stat && pwdata[8]) |=> ofs_guard_r)
      else $error("low-bit guard flag lost");
   a_wr_count : assert property (@(posedge core_clk) disable iff (!resetn)
      wr_take && mapped && !hit_stat |=> wr_cnt_r == $past(wr_cnt_r) + 8'h01)
      else $error("trim write not counted");
   a_cnt_hold : assert property (@(posedge core_clk) disable iff (!resetn)
      !(wr_take && mapped && !hit_stat) |=> $stable(wr_cnt_r))
      else $error("write count changed without a trim write");

   // Reset state.
   a_reset_vals : assert property (@(posedge core_clk) // RULE_04 RULE_09
      $rose(resetn) |-> fs1_code == `CHTRIM_FS_NOMINAL && ofs1_mag == 8'h00 && !ofs1_neg
         && ofs2_mag == 8'h00 && !ofs2_neg)
      else $error("trim reset values wrong");
   a_reset_bus : assert property (@(posedge core_clk)
      $rose(resetn) |-> !pready && !pslverr && !fs1_update)
      else $error("bus outputs not idle after reset");

   c_fs_write   : cover property (@(posedge core_clk) disable iff (!resetn) wr_take && hit_fs1);
   c_ofs2_write : cover property (@(posedge core_clk) disable iff (!resetn) wr_take && hit_ofs2);
   c_bad_addr   : cover property (@(posedge core_clk) disable iff (!resetn) pslverr);
   c_stat_read  : cover property (@(posedge core_clk) disable iff (!resetn)
      take && !pwrite && hit_stat);
   c_guard_set  : cover property (@(posedge core_clk) disable iff (!resetn)
      wr_take && mapped && !hit_stat && pwdata[6:0] != 7'h7F);

endmodule

//--- verif/chtrim_host.sv
// Host model that writes and reads the trim bank over APB.
`timescale 1ns/1ps
`include "chtrim_consts.svh"

module chtrim_host (
   input  wire logic                      core_clk, // Core clock.
   output logic                           psel,     // APB select.
   output logic                           penable,  // APB access phase.
   output logic                           pwrite,   // APB direction.
   output logic [`CHTRIM_ADDR_W-1:0]      paddr,    // APB byte address.
   output logic [31:0]                    pwdata,   // APB write data.
   input  wire logic [31:0]               prdata,   // APB read data.
   input  wire logic                      pready,   // APB ready.
   input  wire logic                      pslverr   // APB error.
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // Ready, data and error are read right at the rising edge, before the flops update.
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic ok);
      int n;
      ok  = 1'b0;
      rd  = '0;
      err = 1'b0;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge core_clk);
         if (pready === 1'b1) begin
            ok  = 1'b1;
            rd  = prdata;
            err = pslverr;
         end
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask

   task automatic write_trim(input logic [5:0] a, input logic [15:0] v, output logic ok);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, a, {16'h0000, v | 16'h007F}, rd, err, ok);
   endtask
endmodule

//--- verif/channel_trim_registers_tb.sv
// Self-checking bench for the channel trim register bank.
`timescale 1ns/1ps
`include "chtrim_consts.svh"

module channel_trim_registers_tb;
   typedef struct packed {
      logic [5:0]  addr;
      logic [15:0] data;
      logic [8:0]  field;
   } chtrim_row_s;

   localparam chtrim_row_s ROWS [9] = '{
      '{6'h08, 16'hA5FF, 9'h14B}, '{6'h08, 16'hFF7F, 9'h1FE}, '{6'h08, 16'h007F, 9'h000},
      '{6'h0C, 16'h607F, 9'h0C0}, '{6'h0C, 16'hE07F, 9'h1C0}, '{6'h0C, 16'h007F, 9'h000},
      '{6'h0C, 16'hFFFF, 9'h1FF}, '{6'h28, 16'h3CFF, 9'h079}, '{6'h28, 16'hC37F, 9'h186}};
   localparam logic [5:0] BAD_ADDR [3] = '{6'h10, 6'h0A, 6'h0D};

   logic        core_clk = 1'b0;
   logic        resetn;
   logic        psel, penable, pwrite, pready, pslverr, fs1_update, ofs1_neg, ofs2_neg, ok, err;
   logic [5:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  ofs1_mag, ofs2_mag;
   logic [8:0]  fs1_code;
   int          mismatches;
   int          tests_run;

   always #4 core_clk = ~core_clk;

   chtrim_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   chtrim_regs DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ofs1_mag(ofs1_mag), .ofs1_neg(ofs1_neg), .fs1_code(fs1_code),
      .fs1_update(fs1_update), .ofs2_mag(ofs2_mag), .ofs2_neg(ofs2_neg));

   function automatic logic [8:0] field_of(input logic [5:0] a);
      case (a)
         6'h08:   field_of = {ofs1_mag, ofs1_neg};
         6'h0C:   field_of = fs1_code;
         default: field_of = {ofs2_mag, ofs2_neg};
      endcase
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check_reset();
      check("ofs1", {ofs1_mag, ofs1_neg}, 9'h000);
      check("fs1", fs1_code, `CHTRIM_FS_NOMINAL);
      check("ofs2", {ofs2_mag, ofs2_neg}, 9'h000);
      check("fs1_update", fs1_update, 1'b0);
      check("pready", pready, 1'b0);
   endtask

   initial begin
      repeat (100000) @(posedge core_clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      resetn = 1'b0;
      mismatches = 0;
      tests_run = 0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      check_reset();
      @(posedge core_clk);
      resetn <= 1'b1;
      // Full-scale rows 0C0h and 1C0h are the recommended bounds; 000h and 1FFh probe the ends.
      foreach (ROWS[i]) begin
         host.write_trim(ROWS[i].addr, ROWS[i].data, ok);
         check("ready", ok, 1'b1);
         @(negedge core_clk);
         check("field", field_of(ROWS[i].addr), ROWS[i].field);
         check("update", fs1_update, ROWS[i].addr == 6'h0C);
         @(negedge core_clk);
         check("update end", fs1_update, 1'b0);
         host.xfer(1'b0, ROWS[i].addr, 32'h0, rd, err, ok);
         check("readback", rd, 32'h0);
         check("read err", err, 1'b0);
      end
      // Refused writes must leave every trim code untouched.
      foreach (BAD_ADDR[i]) begin
         host.xfer(1'b1, BAD_ADDR[i], 32'h0000_2A7F, rd, err, ok);
         check("refused", err, 1'b1);
         @(negedge core_clk);
         check("ofs1 kept", {ofs1_mag, ofs1_neg}, 9'h000);
         check("fs1 kept", fs1_code, 9'h1FF);
         check("ofs2 kept", {ofs2_mag, ofs2_neg}, 9'h186);
      end
      host.xfer(1'b0, {`CHTRIM_IDX_STATUS, 2'b00}, 32'h0, rd, err, ok);
      check("status", rd, 32'h0000_0009);
      // A trim write with clear low bits sets the sticky flag; a status write with bit 8 set clears it.
      host.xfer(1'b1, 6'h28, 32'h0000_5A00, rd, err, ok);
      @(negedge core_clk);
      check("ofs2 raw", {ofs2_mag, ofs2_neg}, 9'h0B4);
      host.xfer(1'b0, 6'h3C, 32'h0, rd, err, ok);
      check("guard set", rd, 32'h0000_010A);
      host.xfer(1'b1, 6'h3C, 32'h0000_0100, rd, err, ok);
      host.xfer(1'b0, 6'h3C, 32'h0, rd, err, ok);
      check("guard clear", rd, 32'h0000_000A);
      @(posedge core_clk);
      resetn <= 1'b0;
      @(negedge core_clk);
      check_reset();
      @(posedge core_clk);
      resetn <= 1'b1;
      @(negedge core_clk);
      check_reset();
      host.write_trim(6'h0C, 16'h6000, ok);
      check("ready", ok, 1'b1);
      @(negedge core_clk);
      check("fs1 after reset", fs1_code, 9'h0C0);
      check("update after reset", fs1_update, 1'b1);
      give_verdict();
   end
endmodule
